// *** shared/idc_pkg.sv ***
// Constants, opcode patterns and decoded-instruction types for the instruction decoder.
package idc_pkg;

    // One instruction cycle is this many oscillator clocks.
    localparam int unsigned OSC_PER_CYC = 4;
    localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYC - 1);
    localparam logic [1:0] PHASE_RST = 2'h0;

    localparam int unsigned INSTR_W = 14;
    localparam int unsigned FILE_W = 7;
    localparam int unsigned BITN_W = 3;
    localparam int unsigned LIT8_W = 8;
    localparam int unsigned LIT11_W = 11;

    // Field positions inside the instruction word.
    localparam int unsigned DEST_POS = 7;
    localparam int unsigned BITN_LSB = 7;
    localparam int unsigned BITWR_POS = 11;
    localparam int unsigned INC_PTR_POS = 2;
    localparam int unsigned OFS_PTR_POS = 6;

    // File address range and the indirect register locations.
    localparam logic [6:0] FILE_ADDR_MAX = 7'h7F;
    localparam logic [5:0] IND_ADDR_HI = 6'h00;

    // Opcode patterns, matched as (word & mask) == value.
    localparam logic [13:0] M_FULL = 14'h3FFF;
    localparam logic [13:0] V_RET = 14'h0008;
    localparam logic [13:0] V_RETINT = 14'h0009;
    localparam logic [13:0] V_CALL_WORK = 14'h000A;
    localparam logic [13:0] V_BR_WORK = 14'h000B;
    localparam logic [13:0] M_ABS = 14'h3800;
    localparam logic [13:0] V_CALL = 14'h2000;
    localparam logic [13:0] V_JUMP = 14'h2800;
    localparam logic [13:0] M_RETLIT = 14'h3F00;
    localparam logic [13:0] V_RETLIT = 14'h3400;
    localparam logic [13:0] M_BRREL = 14'h3E00;
    localparam logic [13:0] V_BRREL = 14'h3200;
    localparam logic [13:0] M_PTRINC = 14'h3FF0;
    localparam logic [13:0] V_PTRINC = 14'h0010;
    localparam logic [13:0] M_PTROFS = 14'h3F00;
    localparam logic [13:0] V_PTROFS = 14'h3F00;
    localparam logic [13:0] M_SKZ = 14'h3F00;
    localparam logic [13:0] V_DEC_SKZ = 14'h0B00;
    localparam logic [13:0] V_INC_SKZ = 14'h0F00;
    localparam logic [13:0] M_BITSKIP = 14'h3800;
    localparam logic [13:0] V_BITSKIP = 14'h1800;

    localparam logic [1:0] GRP_00 = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] GRP_11 = 2'h3;

    typedef enum logic [1:0] {
        CAT_BYTE = 2'b00,
        CAT_BIT = 2'b01,
        CAT_LIT = 2'b10
    } idc_cat_t;

    typedef enum logic [1:0] {
        ST_EXEC = 2'b00,
        ST_STALL = 2'b01,
        ST_FLUSH = 2'b10
    } idc_state_t;

    typedef struct packed {
        idc_cat_t cat;
        logic dest_file;
        logic [FILE_W-1:0] file_addr;
        logic [BITN_W-1:0] bit_num;
        logic ptr_num;
        logic [1:0] pointer_update_mode;
        logic [LIT8_W-1:0] lit8;
        logic [LIT11_W-1:0] lit11;
        logic file_rd;
        logic wr_work;
        logic wr_file;
        logic two_cyc;
        logic skip_type;
        logic ind_ref;
    } idc_dec_t;

endpackage

// *** test/idc_checker.sv ***
// Port-level timing checks for the instruction decoder.
`timescale 1ns/1ps
module idc_checker
    import idc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic [INSTR_W-1:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic skip_taken_i,
    input wire logic [1:0] ptr_in_prog_i,
    input wire logic fetch_o,
    input wire logic cycle_end_o,
    input wire logic [1:0] phase_o,
    input wire idc_dec_t dec_o,
    input wire logic exec_o,
    input wire logic nop_o,
    input wire logic stall_o,
    input wire logic [1:0] last_cycles_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // Cycle-count checks assume the clock enable stays high from a fetch on; the bench freezes only plain words.
    wire tk = fetch_o && instr_valid_i;
    wire is_call = (instr_i & M_ABS) == V_CALL || instr_i == V_CALL_WORK;
    wire is_ret = instr_i == V_RET || instr_i == V_RETINT || (instr_i & M_RETLIT) == V_RETLIT;
    wire is_br = (instr_i & M_ABS) == V_JUMP || (instr_i & M_BRREL) == V_BRREL || instr_i == V_BR_WORK;
    wire ind_hit = exec_o && cycle_end_o && dec_o.ind_ref && ptr_in_prog_i[dec_o.ptr_num];
    chk_phase_wrap: assert property (clk_en_i && phase_o == PHASE_LAST |=> phase_o == PHASE_RST)
        else $error("phase did not wrap");
    chk_end_phase: assert property (cycle_end_o |-> phase_o == PHASE_LAST && clk_en_i)
        else $error("cycle end off phase");
    chk_fetch_end: assert property (fetch_o |-> cycle_end_o)
        else $error("fetch outside cycle end");
    chk_plain_one: assert property (tk && instr_i[13:11] == 3'h2 && instr_i[6:1] != 6'h00
        |=> ##3 fetch_o ##1 last_cycles_o == 2'h1)
        else $error("plain op not one cycle");
    chk_call_two: assert property (tk && is_call |=> ##3 !fetch_o ##1 nop_o[*4] ##1 !nop_o)
        else $error("call not two cycles");
    chk_ret_two: assert property (tk && is_ret |=> ##7 fetch_o ##1 last_cycles_o == 2'h2)
        else $error("return not two cycles");
    chk_jump_two: assert property (tk && is_br |=> ##4 nop_o && !exec_o ##4 !nop_o)
        else $error("branch not two cycles");
    chk_skip_nop: assert property (exec_o && cycle_end_o && dec_o.skip_type && skip_taken_i && !dec_o.ind_ref
        |-> !fetch_o ##1 nop_o)
        else $error("taken skip without flush");
    chk_ind_stall: assert property (ind_hit |-> !fetch_o ##1 stall_o[*4] ##1 !stall_o)
        else $error("indirect stall wrong");
    chk_nop_quiet: assert property (nop_o || stall_o |-> !exec_o && $stable(dec_o))
        else $error("flush cycle executes");
    chk_file_read: assert property (exec_o && dec_o.cat != CAT_LIT |-> dec_o.file_rd)
        else $error("file op without read");
    chk_bit_read: assert property (tk && instr_i[13:12] == GRP_BIT |=> dec_o.file_rd && dec_o.cat == CAT_BIT)
        else $error("bit op without read");
    chk_freeze_hold: assert property (!clk_en_i |=> $stable(phase_o) && $stable(dec_o))
        else $error("state moved while frozen");
endmodule
bind idc_decoder idc_checker u_chk (.*);

// *** test/idc_decoder_tb.sv ***
// Self-checking bench for the instruction decoder.
`timescale 1ns/1ps
module idc_decoder_tb;
    import idc_pkg::*;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic skip_taken_i = 1'b0;
    logic [1:0] ptr_in_prog_i = 2'h0;
    logic slow = 1'b0;
    logic clk_en = 1'b1;
    logic [INSTR_W-1:0] word = 14'h0000;
    logic [INSTR_W-1:0] instr;
    logic valid, fetch_o, cycle_end_o, exec_o, nop_o, stall_o;
    logic [1:0] phase_o, last_cycles_o;
    idc_dec_t dec_o, seen;
    int err_count = 0;
    int total_checks = 0;
    int ticks = 0;
    idc_decoder dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en), .instr_i(instr),
        .instr_valid_i(valid), .skip_taken_i(skip_taken_i), .ptr_in_prog_i(ptr_in_prog_i), .fetch_o(fetch_o),
        .cycle_end_o(cycle_end_o), .phase_o(phase_o), .dec_o(dec_o), .exec_o(exec_o), .nop_o(nop_o),
        .stall_o(stall_o), .last_cycles_o(last_cycles_o));
    idc_prog_mem prog (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .fetch_i(fetch_o), .slow_i(slow),
        .word_i(word), .instr_o(instr), .valid_o(valid));
    initial forever #12.5 ref_clk_i = ~ref_clk_i;
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk_i)
    begin
        ticks <= ticks + 1;
        if (ticks == 4000)
        begin
            err_count = err_count + 1;
            print_verdict();
        end
    end
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // Resets, runs one word and measures clocks from its fetch to the next fetch.
    task automatic run(input logic [13:0] w, input logic sk, input logic [1:0] pp, input int n, input int lc);
        int c;
        @(negedge ref_clk_i);
        word = w;
        skip_taken_i = sk;
        ptr_in_prog_i = pp;
        nrst_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        c = 0;
        while (!fetch_o && c < 20)
        begin
            @(negedge ref_clk_i);
            c++;
        end
        c = 0;
        do
        begin
            @(negedge ref_clk_i);
            c++;
            if (c == 1)
                seen = dec_o;
        end
        while (!fetch_o && c < 20);
        check("cycle_clocks", 16'(4 * n), 16'(c));
        @(negedge ref_clk_i);
        check("last_cycles", 16'(lc), {14'h0, last_cycles_o});
    endtask
    task automatic t_byte;
        run(14'h00A5, 1'b0, 2'h0, 1, 1);
        check("cat", 16'(CAT_BYTE), 16'(seen.cat));
        check("file", 16'h25, 16'(seen.file_addr));
        check("rd", 16'h1, 16'(seen.file_rd));
        check("wr_file", 16'h1, 16'(seen.wr_file));
        check("dest", 16'h1, 16'(seen.dest_file));
        run(14'h3585, 1'b0, 2'h0, 1, 1);
        check("cat", 16'(CAT_BYTE), 16'(seen.cat));
        check("file", 16'h05, 16'(seen.file_addr));
        run(14'h0925, 1'b0, 2'h0, 1, 1);
        check("wr_work", 16'h1, 16'(seen.wr_work));
        $display("test byte done");
    endtask
    task automatic t_bit_lit;
        run(14'h17FF, 1'b0, 2'h0, 1, 1);
        check("cat", 16'(CAT_BIT), 16'(seen.cat));
        check("bit", 16'h7, 16'(seen.bit_num));
        check("file", 16'h7F, 16'(seen.file_addr));
        run(14'h3EA5, 1'b0, 2'h0, 1, 1);
        check("cat", 16'(CAT_LIT), 16'(seen.cat));
        check("lit8", 16'hA5, 16'(seen.lit8));
        $display("test bit and literal done");
    endtask
    task automatic t_flow;
        logic [13:0] two [6] = '{14'h000A, 14'h0008, 14'h0009, 14'h3455, 14'h3201, 14'h000B};
        run(14'h2123, 1'b0, 2'h0, 2, 2);
        check("lit11", 16'h123, 16'(seen.lit11));
        run(14'h2FFF, 1'b0, 2'h0, 2, 2);
        for (int i = 0; i < 6; i++)
            run(two[i], 1'b0, 2'h0, 2, 2);
        $display("test calls returns branches done");
    endtask
    task automatic t_skip;
        run(14'h1CA0, 1'b1, 2'h0, 2, 2);
        run(14'h1CA0, 1'b0, 2'h0, 1, 1);
        run(14'h0BA0, 1'b1, 2'h0, 2, 2);
        run(14'h0FA0, 1'b1, 2'h0, 2, 2);
        $display("test skips done");
    endtask
    task automatic t_ind;
        run(14'h0880, 1'b0, 2'h1, 2, 2);
        run(14'h0880, 1'b0, 2'h2, 1, 1);
        check("ptr", 16'h0, 16'(seen.ptr_num));
        run(14'h3F40, 1'b0, 2'h2, 2, 2);
        check("ptr", 16'h1, 16'(seen.ptr_num));
        run(14'h1C81, 1'b1, 2'h2, 3, 3);
        for (int m = 0; m < 4; m++)
        begin
            run(14'h0014 | 14'(m), 1'b0, 2'h2, 2, 2);
            check("mode", 16'(m), 16'(seen.pointer_update_mode));
            check("ptr", 16'h1, 16'(seen.ptr_num));
        end
        $display("test indirect done");
    endtask
    // Freezes the block in mid-instruction; the phase must stand, then the cycle ends on time.
    task automatic t_freeze;
        @(negedge ref_clk_i);
        word = 14'h00A5;
        skip_taken_i = 1'b0;
        ptr_in_prog_i = 2'h0;
        nrst_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        repeat (5) @(negedge ref_clk_i);
        clk_en = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        check("frozen_phase", 16'h1, {14'h0, phase_o});
        check("frozen_addr", 16'h25, 16'(dec_o.file_addr));
        clk_en = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        check("thawed_fetch", 16'h1, {15'h0, fetch_o});
        @(negedge ref_clk_i);
        check("thawed_cycles", 16'h1, {14'h0, last_cycles_o});
        $display("test freeze done");
    endtask
    task automatic t_bubble;
        slow = 1'b1;
        run(14'h2123, 1'b0, 2'h0, 1, 0);
        slow = 1'b0;
        $display("test bubble done");
    endtask
    initial
    begin
        t_byte();
        t_bit_lit();
        t_flow();
        t_skip();
        t_ind();
        t_freeze();
        t_bubble();
        print_verdict();
    end
endmodule

// *** test/idc_prog_mem.sv ***
// Program memory model: one test word (one junk word when slow), then no-operation words.
`timescale 1ns/1ps
module idc_prog_mem
    import idc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic fetch_i,
    input wire logic slow_i,
    input wire logic [INSTR_W-1:0] word_i,
    output logic [INSTR_W-1:0] instr_o,
    output logic valid_o
);
    logic taken_q;
    // A slow answer misses the first fetch; the line then shows junk rather than a held word.
    assign valid_o = taken_q || !slow_i;
    assign instr_o = !valid_o ? ~word_i : taken_q ? 14'h0000 : word_i;
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            taken_q <= 1'b0;
        else if (fetch_i)
            taken_q <= 1'b1;
    end
endmodule

// *** verilog/idc_decoder.sv ***
// Instruction decoder and instruction-cycle sequencer for the 14-bit core.
//
// What this block does
// RULE1 - Take each 14-bit word whole per instruction.
// RULE2 - Sort words into byte, bit, literal groups.
// RULE3 - Ordinary instructions finish in one cycle.
// RULE4 - Both subroutine calls take two cycles.
// RULE5 - All three return kinds take two cycles.
// RULE6 - Jumps, branches, taken skips take two cycles.
// RULE7 - Indirect access to program memory adds one.
// RULE8 - Instruction cycle is four oscillator clocks.
// RULE9 - File-naming instructions always read the register.
// RULE10 - Destination bit picks working or file register.
// RULE11 - File address spans 0x00 to 0x7F.
// RULE12 - Bit number picks one of eight bits.
// RULE13 - Pointer number selects pointer zero or one.
// RULE14 - Two-bit mode picks pre/post increment/decrement.
// RULE15 - Bit ops hold 3-bit number, 7-bit address.
// RULE16 - General literals take the low eight bits.
// RULE17 - Absolute call and jump take 11-bit target.
// RULE18 - Second cycle discards prefetch, acts as no-op.
`timescale 1ns/1ps

module idc_decoder
    import idc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic [INSTR_W-1:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic skip_taken_i,
    input wire logic [1:0] ptr_in_prog_i,
    output logic fetch_o,
    output logic cycle_end_o,
    output logic [1:0] phase_o,
    output idc_dec_t dec_o,
    output logic exec_o,
    output logic nop_o,
    output logic stall_o,
    output logic [1:0] last_cycles_o
);

    function automatic logic op_is(input logic [INSTR_W-1:0] w, input logic [INSTR_W-1:0] m,
                                   input logic [INSTR_W-1:0] v);
        op_is = (w & m) == v;
    endfunction

    function automatic idc_dec_t idc_decode(input logic [INSTR_W-1:0] w);
        idc_dec_t r;
        logic byte_op;
        logic bit_op;
        logic ptr_inc;
        logic ptr_ofs;
        r = '0;
        // RULE2 group sort
        byte_op = (w[13:12] == GRP_00 && w[13:7] != 7'h00)
                  || (w[13:12] == GRP_11 && (w[11:8] == 4'h5 || w[11:8] == 4'h6
                  || w[11:8] == 4'h7 || w[11:8] == 4'hB || w[11:8] == 4'hD));
        bit_op = w[13:12] == GRP_BIT;
        ptr_inc = op_is(w, M_PTRINC, V_PTRINC);
        ptr_ofs = op_is(w, M_PTROFS, V_PTROFS);
        r.cat = byte_op ? CAT_BYTE : (bit_op ? CAT_BIT : CAT_LIT);
        // RULE11 file address field
        r.file_addr = w[FILE_W-1:0] & FILE_ADDR_MAX;
        // RULE12 bit number field
        // RULE15 bit op layout
        r.bit_num = w[BITN_LSB +: BITN_W];
        // RULE16 eight-bit literal
        r.lit8 = w[LIT8_W-1:0];
        // RULE17 eleven-bit target
        r.lit11 = w[LIT11_W-1:0];
        // RULE14 pointer update mode
        r.pointer_update_mode = w[1:0];
        // RULE13 pointer select
        r.ptr_num = ptr_inc ? w[INC_PTR_POS] : (ptr_ofs ? w[OFS_PTR_POS] : w[0]);
        // RULE9 read before modify
        r.file_rd = byte_op || bit_op;
        // RULE10 destination steering
        r.dest_file = byte_op && w[DEST_POS];
        r.wr_work = byte_op && !w[DEST_POS];
        r.wr_file = (byte_op && w[DEST_POS]) || (bit_op && !w[BITWR_POS]);
        // RULE4 calls take two
        // RULE5 returns take two
        // RULE6 jumps and branches take two
        r.two_cyc = op_is(w, M_ABS, V_CALL) || op_is(w, M_FULL, V_CALL_WORK)
                    || op_is(w, M_FULL, V_RET) || op_is(w, M_RETLIT, V_RETLIT)
                    || op_is(w, M_FULL, V_RETINT) || op_is(w, M_ABS, V_JUMP)
                    || op_is(w, M_BRREL, V_BRREL) || op_is(w, M_FULL, V_BR_WORK);
        // RULE6 conditional skips
        r.skip_type = op_is(w, M_BITSKIP, V_BITSKIP) || op_is(w, M_SKZ, V_DEC_SKZ)
                      || op_is(w, M_SKZ, V_INC_SKZ);
        r.ind_ref = ((byte_op || bit_op) && w[FILE_W-1:1] == IND_ADDR_HI) || ptr_inc || ptr_ofs;
        idc_decode = r;
    endfunction

    idc_state_t state_q;
    idc_state_t state_d;
    logic [1:0] phase_q;
    idc_dec_t dec_q;
    logic valid_q;
    logic flush_pend_q;
    logic [1:0] cyc_cnt_q;
    logic [1:0] last_cyc_q;

    wire logic cyc_end;
    wire logic in_exec;
    wire logic need_ind;
    wire logic need_flush;
    wire logic take_word;
    wire logic [1:0] cyc_cnt_inc;

    // RULE8 four clocks per cycle
    assign cyc_end = clk_en_i && phase_q == PHASE_LAST;
    assign in_exec = state_q == ST_EXEC;
    // RULE7 indirect into program memory
    assign need_ind = in_exec && valid_q && dec_q.ind_ref && ptr_in_prog_i[dec_q.ptr_num];
    // RULE3 others end in one
    assign need_flush = valid_q && (dec_q.two_cyc || (dec_q.skip_type && skip_taken_i));
    assign cyc_cnt_inc = 2'(cyc_cnt_q + 2'h1);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_EXEC:
            begin
                if (need_ind)
                    state_d = ST_STALL;
                else if (need_flush)
                    state_d = ST_FLUSH;
            end
            ST_STALL:
            begin
                state_d = flush_pend_q ? ST_FLUSH : ST_EXEC;
            end
            ST_FLUSH:
            begin
                state_d = ST_EXEC;
            end
            default:
            begin
                state_d = ST_EXEC;
            end
        endcase
    end

    // RULE1 whole word per fetch
    assign take_word = cyc_end && state_d == ST_EXEC;

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            phase_q <= PHASE_RST;
        else if (clk_en_i)
            phase_q <= 2'(phase_q + 2'h1);
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= ST_EXEC;
            flush_pend_q <= 1'b0;
        end
        else if (cyc_end)
        begin
            state_q <= state_d;
            if (in_exec)
                flush_pend_q <= need_flush;
        end
    end

    // RULE18 prefetched word dropped
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            dec_q <= '0;
            valid_q <= 1'b0;
        end
        else if (take_word)
        begin
            dec_q <= idc_decode(instr_i);
            valid_q <= instr_valid_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cyc_cnt_q <= 2'h1;
            last_cyc_q <= 2'h0;
        end
        else if (cyc_end)
        begin
            if (state_d == ST_EXEC)
            begin
                cyc_cnt_q <= 2'h1;
                last_cyc_q <= valid_q ? cyc_cnt_q : 2'h0;
            end
            else
            begin
                cyc_cnt_q <= cyc_cnt_inc;
            end
        end
    end

    assign fetch_o = take_word;
    assign cycle_end_o = cyc_end;
    assign phase_o = phase_q;
    assign dec_o = dec_q;
    assign exec_o = in_exec && valid_q;
    // RULE18 no-op second cycle
    assign nop_o = state_q == ST_FLUSH;
    assign stall_o = state_q == ST_STALL;
    assign last_cycles_o = last_cyc_q;

endmodule
